//--- design/aect_pkg.sv
/*
 * Constants, field layouts and state types for the alarm enable and
 * conversion trigger register block.
 * Assumes a host register port with one-cycle strobes and a single clock.
 */
// Operation
// - An alarm event whose source enable bit is 1 drives the alarm output pin active.
// - An alarm event whose source enable bit is 0 leaves the alarm output pin untouched.
// - Enable bits 10 down to 0 reset to 0 and are readable and writable.
// - Writing 1 to trigger bit 1 loads all DACs set for synchronous mode at once.
// - The DAC load trigger bit clears itself once the DAC data registers are updated.
// - Writing 1 to trigger bit 0 starts an ADC conversion.
// - The ADC conversion trigger bit clears itself as soon as the conversion begins.
// - An ADC trigger written while the converter is not ready is dropped.
// - Polarity bit 0 makes the alarm output active low, 1 makes it active high.
// - Source select 0 routes channel limits to internal ADC inputs, 1 to current sense.
package aect_pkg;
    localparam int          AECT_AW          = 8;
    localparam int          AECT_DW          = 16;
    localparam int          AECT_NSRC        = 11;
    localparam int          AECT_NDAC        = 8;
    localparam logic [7:0]  AECT_ADDR_ALMCFG = 8'h1b;
    localparam logic [7:0]  AECT_ADDR_TRIG   = 8'h1c;
    localparam logic [7:0]  AECT_ADDR_IRQST  = 8'h30;
    localparam logic [7:0]  AECT_ADDR_IRQMSK = 8'h31;
    localparam logic [7:0]  AECT_ADDR_STAT   = 8'h32;
    localparam logic [15:0] AECT_RST_ALMCFG  = 16'h0000;
    localparam logic [15:0] AECT_ALMCFG_MASK = 16'h67ff;
    localparam int          AECT_BIT_POL     = 14;
    localparam int          AECT_BIT_SEL     = 13;
    localparam int          AECT_BIT_DTRIG   = 1;
    localparam int          AECT_BIT_ATRIG   = 0;
    localparam int          AECT_IRQ_DLOAD   = 0;
    localparam int          AECT_IRQ_ASTART  = 1;
    localparam int          AECT_IRQ_ADROP   = 2;
    localparam int          AECT_IRQ_ALARM   = 3;
    localparam int          AECT_NIRQ        = 4;

    typedef enum logic [1:0] {
        AECT_TRIG_IDLE,
        AECT_TRIG_WAIT,
        AECT_TRIG_DONE
    } aect_trig_state_type;
endpackage

//--- design/aect_top.sv
/*
 * Alarm enable configuration and conversion trigger registers with alarm
 * output and status interrupt.
 * Assumes a host port with one-cycle strobes, read data one cycle later,
 * and alarm condition levels synchronous to CLK.
 */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module aect_top
    import aect_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    input  wire logic [AECT_AW-1:0]   ADDR,
    input  wire logic [AECT_DW-1:0]   WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [AECT_DW-1:0]   RDATA,
    input  wire logic [AECT_NSRC-1:0] ALARM_COND,
    input  wire logic [AECT_NDAC-1:0] DAC_SYNC_MODE,
    input  wire logic                 DAC_LOAD_DONE,
    input  wire logic                 ADC_READY,
    input  wire logic                 ADC_STARTED,
    output logic      [AECT_NDAC-1:0] DAC_LOAD,
    output logic                      ADC_START,
    output logic                      CHAN_SRC_CURRENT,
    output logic                      ALARM_OUTPUT_PIN,
    output logic                      IRQ
);
    typedef struct packed {
        logic [AECT_DW-1:0]   almcfg;
        logic [AECT_DW-1:0]   rdata;
        logic [AECT_NIRQ-1:0] irq_st;
        logic [AECT_NIRQ-1:0] irq_msk;
        logic [AECT_NDAC-1:0] dac_load;
        logic                 adc_start;
        logic                 src_sel;
        logic                 pin;
        logic                 irq;
        logic                 alarm_d;
    } aect_top_type;

    aect_top_type r_r;
    aect_top_type r_nxt;

    aect_trig_if dac_if ();
    aect_trig_if adc_if ();

    logic dac_cmd;
    logic adc_cmd;
    logic adc_drop;
    logic wr_trig;
    logic alarm_any;

    function automatic logic hit(input logic [AECT_AW-1:0] a, input logic [AECT_AW-1:0] r);
        hit = (a == r);
    endfunction

    // Reserved trigger bits are ignored, the host keeps them zero
    assign wr_trig     = WR && hit(ADDR, AECT_ADDR_TRIG);
    assign dac_if.req  = wr_trig && WDATA[AECT_BIT_DTRIG];
    assign adc_if.req  = wr_trig && WDATA[AECT_BIT_ATRIG];
    assign alarm_any   = |(ALARM_COND & r_r.almcfg[AECT_NSRC-1:0]);

    aect_trig_seq #(.GATED(1'b0)) u_dac (
        .clk     (CLK),
        .resetn  (RESETN),
        .ready   (1'b1),
        .ack_in  (DAC_LOAD_DONE),
        .cmd     (dac_cmd),
        .dropped (),
        .tif     (dac_if.slave)
    );

    aect_trig_seq #(.GATED(1'b1)) u_adc (
        .clk     (CLK),
        .resetn  (RESETN),
        .ready   (ADC_READY),
        .ack_in  (ADC_STARTED),
        .cmd     (adc_cmd),
        .dropped (adc_drop),
        .tif     (adc_if.slave)
    );

    always_comb begin
        r_nxt           = r_r;
        r_nxt.rdata     = '0;
        r_nxt.alarm_d   = alarm_any;
        if (WR && hit(ADDR, AECT_ADDR_ALMCFG)) begin
            r_nxt.almcfg = WDATA & AECT_ALMCFG_MASK;
        end
        if (WR && hit(ADDR, AECT_ADDR_IRQMSK)) begin
            r_nxt.irq_msk = WDATA[AECT_NIRQ-1:0];
        end
        if (RD) begin
            case (ADDR)
                AECT_ADDR_ALMCFG: r_nxt.rdata = r_r.almcfg;
                AECT_ADDR_IRQST: begin
                    r_nxt.rdata  = {{(AECT_DW-AECT_NIRQ){1'b0}}, r_r.irq_st};
                    r_nxt.irq_st = '0;
                end
                AECT_ADDR_IRQMSK: r_nxt.rdata = {{(AECT_DW-AECT_NIRQ){1'b0}}, r_r.irq_msk};
                AECT_ADDR_STAT: r_nxt.rdata = {{(AECT_DW-3){1'b0}}, alarm_any,
                                               adc_if.busy, dac_if.busy};
                default: r_nxt.rdata = '0;
            endcase
        end
        // Set after the read clear so a same-cycle event is kept
        if (dac_if.ack) r_nxt.irq_st[AECT_IRQ_DLOAD] = 1'b1;
        if (adc_if.ack) r_nxt.irq_st[AECT_IRQ_ASTART] = 1'b1;
        if (adc_drop) r_nxt.irq_st[AECT_IRQ_ADROP] = 1'b1;
        if (alarm_any && !r_r.alarm_d) r_nxt.irq_st[AECT_IRQ_ALARM] = 1'b1;
        r_nxt.dac_load  = dac_cmd ? DAC_SYNC_MODE : '0;
        r_nxt.adc_start = adc_cmd;
        r_nxt.src_sel   = r_r.almcfg[AECT_BIT_SEL];
        // Polarity 0 means active low pin
        r_nxt.pin       = alarm_any ~^ r_r.almcfg[AECT_BIT_POL];
        r_nxt.irq       = |(r_nxt.irq_st & r_nxt.irq_msk);
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            r_r          <= '0;
            r_r.almcfg   <= AECT_RST_ALMCFG;
            r_r.pin      <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign RDATA            = r_r.rdata;
    assign DAC_LOAD         = r_r.dac_load;
    assign ADC_START        = r_r.adc_start;
    assign CHAN_SRC_CURRENT = r_r.src_sel;
    assign ALARM_OUTPUT_PIN = r_r.pin;
    assign IRQ              = r_r.irq;

    AST_ENABLED_ALARM: assert property (@(posedge CLK) disable iff (!RESETN)
        ((ALARM_COND & r_r.almcfg[AECT_NSRC-1:0]) != '0) |=>
            ALARM_OUTPUT_PIN == $past(r_r.almcfg[AECT_BIT_POL]))
        else $error("enabled alarm did not reach pin");
    AST_MASKED_ALARM: assert property (@(posedge CLK) disable iff (!RESETN)
        ((ALARM_COND & r_r.almcfg[AECT_NSRC-1:0]) == '0) |=>
            ALARM_OUTPUT_PIN != $past(r_r.almcfg[AECT_BIT_POL]))
        else $error("disabled alarm reached pin");
    AST_CFG_READBACK: assert property (@(posedge CLK) disable iff (!RESETN)
        (WR && ADDR == AECT_ADDR_ALMCFG) ##1 (RD && ADDR == AECT_ADDR_ALMCFG && !WR) |=>
            RDATA[AECT_NSRC-1:0] == $past(WDATA[AECT_NSRC-1:0], 2))
        else $error("enable bits did not read back");
    AST_DAC_LOAD: assert property (@(posedge CLK) disable iff (!RESETN)
        (dac_if.req && !dac_if.busy) |=> ##1 DAC_LOAD == $past(DAC_SYNC_MODE))
        else $error("sync DACs not loaded");
    AST_DAC_CLEAR: assert property (@(posedge CLK) disable iff (!RESETN)
        (dac_cmd && DAC_LOAD_DONE) |=> ##1 DAC_LOAD == '0)
        else $error("DAC trigger did not self clear");
    AST_ADC_START: assert property (@(posedge CLK) disable iff (!RESETN)
        (adc_if.req && ADC_READY && !adc_if.busy) |=> ##1 ADC_START)
        else $error("ADC start missing");
    AST_ADC_CLEAR: assert property (@(posedge CLK) disable iff (!RESETN)
        (adc_cmd && ADC_STARTED) |=> ##1 !ADC_START)
        else $error("ADC trigger did not self clear");
    AST_ADC_DROP: assert property (@(posedge CLK) disable iff (!RESETN)
        (adc_if.req && !ADC_READY && !adc_if.busy) |=> ##1 !ADC_START)
        else $error("ADC started while not ready");
    AST_SRC_SEL: assert property (@(posedge CLK) disable iff (!RESETN)
        1'b1 |=> CHAN_SRC_CURRENT == $past(r_r.almcfg[AECT_BIT_SEL]))
        else $error("source select mismatch");

    COV_DAC: cover property (@(posedge CLK) dac_if.req ##[1:20] dac_if.ack);
    COV_ADC: cover property (@(posedge CLK) adc_if.req ##[1:20] adc_if.ack);
    COV_DROP: cover property (@(posedge CLK) adc_drop);
    COV_PIN_HIGH: cover property (@(posedge CLK) alarm_any && r_r.almcfg[AECT_BIT_POL]);
endmodule // aect_top

//--- design/aect_trig_if.sv
/*
 * Interface carrying one trigger request and its completion between the
 * register top and the trigger sequencer.
 * Assumes both ends share the block clock.
 */
`timescale 1ns/1ps
interface aect_trig_if;
    logic req;
    logic ack;
    logic busy;
    logic fire;
    modport master (output req, input ack, input busy, input fire);
    modport slave  (input req, output ack, output busy, output fire);
endinterface

//--- design/aect_trig_seq.sv
/*
 * Trigger sequencer: turns a one-cycle request into a command pulse held
 * until the datapath acknowledges, optionally gated by a ready level.
 * Assumes ack is a level or pulse synchronous to CLK.
 */
`timescale 1ns/1ps
module aect_trig_seq
    import aect_pkg::*;
#(
    parameter bit GATED = 1'b0
) (
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ready,
    input  wire logic  ack_in,
    output logic       cmd,
    output logic       dropped,
    aect_trig_if.slave tif
);
    typedef struct packed {
        aect_trig_state_type st;
        logic                cmd;
        logic                drop;
        logic                done;
    } aect_seq_type;

    aect_seq_type s_r;
    aect_seq_type s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.drop = 1'b0;
        s_nxt.done = 1'b0;
        case (s_r.st)
            AECT_TRIG_IDLE: begin
                if (tif.req) begin
                    if (GATED && !ready) begin
                        s_nxt.drop = 1'b1;
                    end else begin
                        s_nxt.st  = AECT_TRIG_WAIT;
                        s_nxt.cmd = 1'b1;
                    end
                end
            end
            AECT_TRIG_WAIT: begin
                if (ack_in) begin
                    s_nxt.st   = AECT_TRIG_DONE;
                    s_nxt.cmd  = 1'b0;
                    s_nxt.done = 1'b1;
                end
            end
            AECT_TRIG_DONE: s_nxt.st = AECT_TRIG_IDLE;
            default:        s_nxt = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd      = s_r.cmd;
    assign dropped  = s_r.drop;
    assign tif.ack  = s_r.done;
    assign tif.busy = (s_r.st != AECT_TRIG_IDLE);
    assign tif.fire = s_r.cmd;

    AST_DROP_NO_CMD: assert property (@(posedge clk) disable iff (!resetn)
        (GATED && tif.req && !ready && s_r.st == AECT_TRIG_IDLE) |=> dropped && !cmd)
        else $error("request while not ready was not dropped");
    AST_CMD_UNTIL_ACK: assert property (@(posedge clk) disable iff (!resetn)
        (cmd && !ack_in) |=> cmd)
        else $error("command fell before acknowledge");
endmodule // aect_trig_seq

//--- verif/aect_far_model.sv
/*
 * Far-side model of the DAC and ADC datapath: answers load and start
 * commands after a settable number of cycles.
 * Assumes commands are levels synchronous to clk.
 */
`timescale 1ns/1ps
module aect_far_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] dac_load,
    input  wire logic       adc_start,
    input  wire logic       adc_ok,
    input  wire logic [3:0] dly,
    output logic            load_done,
    output logic            conv_started,
    output logic            adc_ready
);
    logic [4:0] dcnt_r;
    logic [4:0] acnt_r;

    // Not ready while converting, so a trigger mid-conversion is refused
    assign adc_ready = adc_ok & ~adc_start;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dcnt_r       <= 5'h00;
            acnt_r       <= 5'h00;
            load_done    <= 1'b0;
            conv_started <= 1'b0;
        end else begin
            dcnt_r       <= (|dac_load) ? dcnt_r + 5'h01 : 5'h00;
            acnt_r       <= adc_start ? acnt_r + 5'h01 : 5'h00;
            load_done    <= (|dac_load) && (dcnt_r == {1'b0, dly});
            conv_started <= adc_start && (acnt_r == {1'b0, dly});
        end
    end
endmodule // aect_far_model

//--- verif/alarm_enable_and_conv_trigger_test.sv
/*
 * Self-checking bench for the alarm enable and trigger registers.
 * Assumes aect_top, aect_far_model and one 20 MHz clock.
 */
`timescale 1ns/1ps
module alarm_enable_and_conv_trigger_test;
    import aect_pkg::*;
    typedef struct packed {logic [15:0] cfg; logic [10:0] cnd; logic pin;} aect_row_type;
    aect_row_type rows [6] = '{'{16'h0000, 11'h7ff, 1'b1}, '{16'h07ff, 11'h001, 1'b0},
        '{16'h4400, 11'h400, 1'b1}, '{16'h4000, 11'h7ff, 1'b0},
        '{16'h2155, 11'h0aa, 1'b1}, '{16'hffff, 11'h7ff, 1'b1}};
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [10:0] cond = 11'h000;
    logic [7:0]  sync = 8'ha5;
    logic        adc_ok = 1'b1;
    logic [3:0]  dly = 4'h0;
    logic [15:0] rdata, v;
    logic [7:0]  load;
    logic        done, ready, started, start, src, pin, irq;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          i, k;

    initial forever #25 clk = ~clk;

    aect_top dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .ALARM_COND(cond), .DAC_SYNC_MODE(sync),
        .DAC_LOAD_DONE(done), .ADC_READY(ready), .ADC_STARTED(started), .DAC_LOAD(load),
        .ADC_START(start), .CHAN_SRC_CURRENT(src), .ALARM_OUTPUT_PIN(pin), .IRQ(irq));
    aect_far_model far (.clk(clk), .resetn(resetn), .dac_load(load), .adc_start(start),
        .adc_ok(adc_ok), .dly(dly), .load_done(done), .conv_started(started),
        .adc_ready(ready));

    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic hang();
        error_cnt++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude();
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Write then read back with no idle cycle between the strobes
    task automatic wrreg(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk(pin, 16'h0001);
        chk({load, start, irq}, 16'h0000);
        rreg(AECT_ADDR_ALMCFG, v);
        chk(v, AECT_RST_ALMCFG);
        for (i = 0; i < 6; i++) begin
            wrreg(AECT_ADDR_ALMCFG, rows[i].cfg, v);
            chk(v, rows[i].cfg & AECT_ALMCFG_MASK);
            @(posedge clk);
            cond <= rows[i].cnd;
            repeat (3) @(negedge clk);
            chk(pin, rows[i].pin);
            chk(src, rows[i].cfg[AECT_BIT_SEL]);
        end
        rreg(AECT_ADDR_TRIG, v);
        chk(v, 16'h0000);
        @(posedge clk);
        cond <= 11'h000;
        // Only the enabled-alarm rising event has happened so far
        rreg(AECT_ADDR_IRQST, v);
        chk(v, 16'h0008);
        // Prompt, then slow far side; interrupt unmasked, then masked
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            dly <= (k == 0) ? 4'h0 : 4'h5;
            wreg(AECT_ADDR_IRQMSK, (k == 0) ? 16'h0001 : 16'h0000);
            wreg(AECT_ADDR_TRIG, 16'h0002);
            for (i = 0; i < 20 && load !== sync; i++) @(negedge clk);
            if (i == 20) hang();
            chk(start, 16'h0000);
            for (i = 0; i < 20 && load !== 8'h00; i++) @(negedge clk);
            if (i == 20) hang();
            @(negedge clk);
            chk(irq, (k == 0) ? 16'h0001 : 16'h0000);
            rreg(AECT_ADDR_IRQST, v);
            chk(v, 16'h0001);
            @(negedge clk);
            chk(irq, 16'h0000);
        end
        wreg(AECT_ADDR_TRIG, 16'h0001);
        for (i = 0; i < 20 && start !== 1'b1; i++) @(negedge clk);
        if (i == 20) hang();
        for (i = 0; i < 20 && start !== 1'b0; i++) @(negedge clk);
        if (i == 20) hang();
        rreg(AECT_ADDR_IRQST, v);
        chk(v, 16'h0002);
        @(posedge clk);
        adc_ok <= 1'b0;
        wreg(AECT_ADDR_TRIG, 16'h0001);
        repeat (4) @(negedge clk);
        chk(start, 16'h0000);
        rreg(AECT_ADDR_IRQST, v);
        chk(v, 16'h0004);
        // Mid-run reset with a non-default config must restore defaults
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk({load, start, src, irq}, 16'h0000);
        chk(pin, 16'h0001);
        rreg(AECT_ADDR_ALMCFG, v);
        chk(v, AECT_RST_ALMCFG);
        conclude();
    end
endmodule // alarm_enable_and_conv_trigger_test
